// *** shared/sfc_pkg.sv ***
// constants shared by the fault supervisor, its crc engine and stretchers
// assumes a 200 MHz core clock; times are kept in their own units
package sfc_pkg;

    // ------------------------------------------------------------
    // clock and times
    // ------------------------------------------------------------
    localparam longint CLK_HZ        = 200_000_000;
    localparam longint THERM_HOLD_MS = 200;
    localparam longint WD_LONG_MS    = 1200;
    localparam longint WD_MID_MS     = 600;
    localparam longint WD_SHORT_MS   = 200;
    localparam longint SC_PULSE_US   = 100;

    localparam longint THERM_HOLD_CYC = THERM_HOLD_MS * CLK_HZ / 1000;
    localparam longint WD_LONG_CYC    = WD_LONG_MS * CLK_HZ / 1000;
    localparam longint WD_MID_CYC     = WD_MID_MS * CLK_HZ / 1000;
    localparam longint WD_SHORT_CYC   = WD_SHORT_MS * CLK_HZ / 1000;
    localparam longint SC_PULSE_CYC   = SC_PULSE_US * CLK_HZ / 1_000_000;

    localparam int HOLD_W = 26;
    localparam int WD_W   = 28;
    localparam int SC_W   = 15;

    // ------------------------------------------------------------
    // crc and frame layout
    // ------------------------------------------------------------
    localparam int           CRC_W     = 7;
    localparam logic [6:0]   CRC_INIT  = 7'h7F;
    localparam logic [6:0]   CRC_POLY  = 7'h37;
    localparam int           CHK_LEAD  = 7;
    localparam int           TX_W      = 24;
    localparam int           CNT_W     = 8;
    localparam logic [7:0]   LEN_SHORT = 8'h10;
    localparam logic [7:0]   LEN_LONG  = 8'h18;
    localparam logic [7:0]   LEN_D8    = 8'h08;
    localparam int           CLR_BIT   = 15;
    localparam int           NCH       = 8;

    // ------------------------------------------------------------
    // global fault bits
    // ------------------------------------------------------------
    localparam int GF_VDD_WARN = 0;
    localparam int GF_VDD_UV   = 1;
    localparam int GF_V5_UV    = 2;
    localparam int GF_THERM    = 3;
    localparam int GF_CLKCNT   = 4;
    localparam int GF_DCDC     = 5;
    localparam int GF_CRC      = 6;
    localparam int GF_WD       = 7;

    // ------------------------------------------------------------
    // watchdog select codes
    // ------------------------------------------------------------
    localparam logic [1:0] WD_OFF   = 2'h0;
    localparam logic [1:0] WD_LONG  = 2'h1;
    localparam logic [1:0] WD_MID   = 2'h2;
    localparam logic [1:0] WD_SHORT = 2'h3;

endpackage

// *** core/sfc_crc7.sv ***
// bit-serial crc7 folded over a whole word, msb first
// assumes the word is stable; purely combinational
`timescale 1ns/10ps
`default_nettype none
module sfc_crc7 import sfc_pkg::*; #(
    parameter int NBITS = 9
) (
    // word in, check bits out
    input  wire logic [NBITS-1:0] data,
    output logic      [6:0]       crc
);
    if (NBITS < 1) $error("sfc_crc7: NBITS must be at least 1");

    always_comb begin
        logic fb;
        crc = CRC_INIT;
        fb  = 1'b0;
        // bits enter in line order, first sent bit first
        for (int i = NBITS - 1; i >= 0; i--) begin
            fb  = data[i] ^ crc[6];
            crc = {crc[5:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00);
        end
    end
endmodule
`default_nettype wire

// *** core/sfc_stretch.sv ***
// holds a fault level high for a least time after it rises
// assumes the input is already synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module sfc_stretch import sfc_pkg::*; #(
    parameter int              CW   = HOLD_W,
    parameter logic [CW-1:0]   HOLD = CW'(THERM_HOLD_CYC)
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // level in and stretched level out
    input  wire logic lvl_in,
    output logic      lvl_out
);
    if (HOLD < 1) $error("sfc_stretch: HOLD must be at least 1");

    logic [CW-1:0] cnt_reg, cnt_next;
    logic          prev_reg;

    always_comb begin
        cnt_next = cnt_reg;
        if (lvl_in && !prev_reg)
            cnt_next = HOLD;
        else if (cnt_reg != '0)
            cnt_next = cnt_reg - CW'(1);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg  <= '0;
            prev_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            prev_reg <= lvl_in;
        end
    end

    // high while the source is high or the hold runs
    assign lvl_out = lvl_in | (cnt_reg != '0);
endmodule
`default_nettype wire

// *** core/sfc_fault_core.sv ***
// fault supervisor and serial-link error checking for an eight-channel driver
// assumes pins arrive asynchronous; spi_clk comes from the controller and
// stops between frames, so frame ends are judged on the core clock
// ------------------------------------------------------------
// Summary of operation
// - channel overheat: that channel off, flag set
// - die overheat: all channels off, flag
// - open load only enabled high-side channels
// - supply lockout: all off, leds off, flag
// - watchdog expiry raises pin until next select
// - clock count not multiple eight: error
// - crc mismatch discards data, sets fault
// - overcurrent: slow mode, short fault pulse
// - normal mode: fault pin follows faults
// - command mode: fault latched until clear
// - thermal indication stretched least 200 ms
// - crc check needs enable and serial mode
// - seven bit crc, poly, init ones
// - crc over data plus leading one
// - apply data only from clean frames
// - error bit reports previous frame
// - reply check bits over status plus error
// - fault bits set at once, held
// - clear only by clean frame clear bit
// ------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module sfc_fault_core import sfc_pkg::*; #(
    parameter logic [HOLD_W-1:0] THERM_HOLD = HOLD_W'(THERM_HOLD_CYC),
    parameter logic [WD_W-1:0]   WD_LONG_T  = WD_W'(WD_LONG_CYC),
    parameter logic [WD_W-1:0]   WD_MID_T   = WD_W'(WD_MID_CYC),
    parameter logic [WD_W-1:0]   WD_SHORT_T = WD_W'(WD_SHORT_CYC),
    parameter logic [SC_W-1:0]   SC_PULSE   = SC_W'(SC_PULSE_CYC)
) (
    // core clock and reset
    input  wire logic           ref_clk,
    input  wire logic           rst,
    // serial link pins
    input  wire logic           spi_clk,
    input  wire logic           cs_n,
    input  wire logic           sdi,
    output logic                sdo,
    // mode pins
    input  wire logic           crc_enable_input,
    input  wire logic           serial_setting_select,
    input  wire logic           cmd_mode,
    // analog detector pins
    input  wire logic [NCH-1:0] therm_hs,
    input  wire logic [NCH-1:0] therm_ls,
    input  wire logic           die_hot,
    input  wire logic           vdd_warn,
    input  wire logic           vdd_uvlo,
    input  wire logic           v5_uvlo,
    input  wire logic           dcdc_limit,
    input  wire logic [NCH-1:0] ol_on_low,
    input  wire logic [NCH-1:0] ol_off_low,
    input  wire logic [NCH-1:0] over_current,
    // configuration from the setting registers
    input  wire logic [NCH-1:0] hs_cmd,
    input  wire logic [NCH-1:0] ls_cmd,
    input  wire logic [NCH-1:0] pp_mode,
    input  wire logic [NCH-1:0] ol_en,
    input  wire logic [1:0]     wd_sel,
    input  wire logic           sc_pulse_off,
    // driver and indicator controls
    output logic [NCH-1:0]      high_side_driver,
    output logic [NCH-1:0]      low_side_driver,
    output logic [NCH-1:0]      slow_mode,
    output logic                leds_off,
    // fault reporting
    output logic                fault_n,
    output logic                watchdog_expiry_output,
    output logic                crc_error_indication,
    output logic                clock_count_error_flag,
    output logic [NCH-1:0]      ol_flags,
    output logic [NCH-1:0]      therm_flags,
    output logic [7:0]          glob_flags,
    // accepted frame data
    output logic [15:0]         rx_data,
    output logic                rx_wide,
    output logic                rx_valid
);
    if (THERM_HOLD < 1 || WD_SHORT_T < 2 || SC_PULSE < 1)
        $error("sfc_fault_core: timing parameters too small");

    // ------------------------------------------------------------
    // link domain: shift in on rise, shift out on fall
    // ------------------------------------------------------------
    logic [TX_W-1:0]  rx_shift_reg, rx_shift_next;
    logic [CNT_W-1:0] bit_cnt_reg, bit_cnt_next;
    logic             sdo_reg, sdo_next, run_reg;
    logic [TX_W-1:0]  tx_word_reg, tx_word_next;

    always_comb begin
        rx_shift_next = {rx_shift_reg[TX_W-2:0], sdi};
        // wraps; the multiple-of-eight test stays exact
        bit_cnt_next  = run_reg ? bit_cnt_reg + CNT_W'(1) : CNT_W'(1);
        // past our reply, received bits pass down the chain
        if (bit_cnt_reg < CNT_W'(TX_W))
            sdo_next = tx_word_reg[5'(TX_W - 1) - bit_cnt_reg[4:0]];
        else
            sdo_next = rx_shift_reg[TX_W-1];
    end

    // the count outlives cs_n rise for the core clock to judge
    always_ff @(posedge spi_clk or posedge cs_n) begin
        if (cs_n)
            run_reg <= 1'b0;
        else
            run_reg <= 1'b1;
    end

    always_ff @(posedge spi_clk) begin
        bit_cnt_reg  <= bit_cnt_next;
        rx_shift_reg <= rx_shift_next;
    end

    always_ff @(negedge spi_clk or posedge cs_n) begin
        if (cs_n)
            sdo_reg <= 1'b0;
        else
            sdo_reg <= sdo_next;
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int SW = 4 * NCH + 9;
    logic [SW-1:0] meta_reg, sync_reg;
    logic          cs_prev_reg;
    logic [NCH-1:0] th_hs_s, th_ls_s, olon_s, oloff_s;
    logic          cs_s, hot_s, warn_s, vuv_s, v5uv_s, dcdc_s;
    logic          crc_en_s, ser_s, cmd_s;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_reg    <= {1'b1, (SW-1)'(0)};
            sync_reg    <= {1'b1, (SW-1)'(0)};
            cs_prev_reg <= 1'b1;
        end else begin
            meta_reg    <= {cs_n, therm_hs, therm_ls, die_hot, vdd_warn, vdd_uvlo,
                            v5_uvlo, dcdc_limit, ol_on_low, ol_off_low,
                            crc_enable_input, serial_setting_select, cmd_mode};
            sync_reg    <= meta_reg;
            cs_prev_reg <= cs_s;
        end
    end

    assign {cs_s, th_hs_s, th_ls_s, hot_s, warn_s, vuv_s, v5uv_s, dcdc_s,
            olon_s, oloff_s, crc_en_s, ser_s, cmd_s} = sync_reg;

    logic [NCH-1:0] oc_meta_reg, oc_sync_reg, oc_prev_reg;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            oc_meta_reg <= '0;
            oc_sync_reg <= '0;
            oc_prev_reg <= '0;
        end else begin
            oc_meta_reg <= over_current;
            oc_sync_reg <= oc_meta_reg;
            oc_prev_reg <= oc_sync_reg;
        end
    end

    // ------------------------------------------------------------
    // stretched per-channel indications
    // ------------------------------------------------------------
    logic [NCH-1:0] th_raw, ol_raw, th_str, ol_str;

    // open load watched only on enabled high-side channels
    assign th_raw = th_hs_s | th_ls_s;
    assign ol_raw = ol_en & ~pp_mode & ((hs_cmd & olon_s) | (~hs_cmd & oloff_s));

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        sfc_stretch #(.CW(HOLD_W), .HOLD(THERM_HOLD)) u_th (
            .clk     (ref_clk),
            .rst     (rst),
            .lvl_in  (th_raw[g]),
            .lvl_out (th_str[g])
        );
        sfc_stretch #(.CW(HOLD_W), .HOLD(THERM_HOLD)) u_ol (
            .clk     (ref_clk),
            .rst     (rst),
            .lvl_in  (ol_raw[g]),
            .lvl_out (ol_str[g])
        );
    end

    // ------------------------------------------------------------
    // frame checking at chip-select rise
    // ------------------------------------------------------------
    logic [6:0] crc_rx9, crc_rx17, crc_tx;
    logic       crc_error_indication_reg, crc_error_indication_next;
    logic [15:0] status16;
    logic [15:0] rx_data_reg, rx_data_next;

    sfc_crc7 #(.NBITS(9)) u_crc_rx9 (
        .data (rx_shift_reg[15:7]),
        .crc  (crc_rx9)
    );
    sfc_crc7 #(.NBITS(17)) u_crc_rx17 (
        .data (rx_shift_reg[23:7]),
        .crc  (crc_rx17)
    );
    sfc_crc7 #(.NBITS(17)) u_crc_tx (
        .data ({status16, crc_error_indication_reg}),
        .crc  (crc_tx)
    );

    logic       frame_end, frame_start, crc_on, ck_err, crc_err, frame_ok, clr;
    logic [7:0] need_len;
    logic [6:0] crc_calc;

    // link registers are read only after cs_n has been high two cycles
    assign frame_end   = cs_s & ~cs_prev_reg;
    assign frame_start = ~cs_s & cs_prev_reg;
    assign crc_on      = crc_en_s & ser_s;
    assign need_len    = (cmd_s ? LEN_SHORT : LEN_D8) + (crc_on ? LEN_D8 : 8'h00);
    assign crc_calc    = cmd_s ? crc_rx17 : crc_rx9;
    assign ck_err      = bit_cnt_reg[2:0] != 3'h0;
    assign crc_err     = crc_on && (bit_cnt_reg < need_len || !rx_shift_reg[CHK_LEAD]
                         || rx_shift_reg[6:0] != crc_calc);
    assign frame_ok    = frame_end && !ck_err && !crc_err && bit_cnt_reg >= need_len;
    assign clr         = frame_ok && cmd_s && rx_data_next[CLR_BIT];

    // ------------------------------------------------------------
    // fault state
    // ------------------------------------------------------------
    logic [NCH-1:0]  olf_reg, olf_next, thf_reg, thf_next, slow_reg, slow_next;
    logic [NCH-1:0]  hs_reg, hs_next, ls_reg, ls_next;
    logic [7:0]      gf_reg, gf_next, gf_set;
    logic [WD_W-1:0] wd_cnt_reg, wd_cnt_next, wd_lim;
    logic            wd_reg, wd_next, wd_fire;
    logic [SC_W-1:0] sc_cnt_reg, sc_cnt_next;
    logic            ckh_reg, ckh_next, irq_reg, irq_next, fault_n_reg, fault_n_next;
    logic            leds_reg, leds_next, rt_fault, glob_off;
    logic            rx_wide_reg, rx_wide_next, rx_valid_reg, rx_valid_next;

    assign status16 = {olf_reg | thf_reg, hs_reg | slow_reg};

    always_comb begin
        case (wd_sel)
            WD_LONG:  wd_lim = WD_LONG_T;
            WD_MID:   wd_lim = WD_MID_T;
            WD_SHORT: wd_lim = WD_SHORT_T;
            default:  wd_lim = '0;
        endcase
        wd_fire     = wd_sel != WD_OFF && !frame_start && wd_cnt_reg == wd_lim - WD_W'(1);
        wd_cnt_next = wd_cnt_reg;
        if (frame_start || wd_sel == WD_OFF)
            wd_cnt_next = '0;
        else if (wd_cnt_reg < wd_lim)
            wd_cnt_next = wd_cnt_reg + WD_W'(1);
        wd_next = wd_reg;
        if (frame_start)
            wd_next = 1'b0;
        else if (wd_fire)
            wd_next = 1'b1;

        gf_set = '0;
        gf_set[GF_VDD_WARN] = warn_s;
        gf_set[GF_VDD_UV]   = vuv_s;
        gf_set[GF_V5_UV]    = v5uv_s;
        gf_set[GF_THERM]    = hot_s;
        gf_set[GF_CLKCNT]   = frame_end && ck_err;
        gf_set[GF_DCDC]     = dcdc_s;
        gf_set[GF_CRC]      = frame_end && crc_err;
        gf_set[GF_WD]       = wd_fire;

        // an event in the clearing cycle survives it
        olf_next  = (clr ? '0 : olf_reg) | ol_str;
        thf_next  = (clr ? '0 : thf_reg) | th_str;
        gf_next   = (clr ? '0 : gf_reg) | gf_set;
        slow_next = (clr ? '0 : slow_reg) | (oc_sync_reg & ~oc_prev_reg);

        // drivers follow the raw thermal signal, not the stretched one
        glob_off = hot_s | vuv_s | v5uv_s;
        hs_next  = hs_cmd & ~th_raw & {NCH{~glob_off}};
        ls_next  = ls_cmd & ~th_raw & {NCH{~glob_off}};
        leds_next = vuv_s | v5uv_s;

        sc_cnt_next = sc_cnt_reg;
        if (|(oc_sync_reg & ~oc_prev_reg) && !sc_pulse_off)
            sc_cnt_next = SC_PULSE;
        else if (sc_cnt_reg != '0)
            sc_cnt_next = sc_cnt_reg - SC_W'(1);

        // clock-count trouble stays a live fault until a clean count
        ckh_next = frame_end ? ck_err : ckh_reg;
        rt_fault = |ol_str | |th_str | hot_s | vuv_s | v5uv_s | ckh_reg;
        irq_next = (clr ? 1'b0 : irq_reg) | rt_fault | gf_set[GF_CLKCNT];
        fault_n_next = !((cmd_s ? irq_next : rt_fault) || sc_cnt_next != '0);

        // rx_data and rx_wide only move on a clean frame, rx_valid pulses for one cycle on it; the crc error bit moves at every frame end
        rx_data_next  = cmd_s ? rx_shift_reg[(crc_on ? 23 : 15) -: 16]
                              : {8'h00, rx_shift_reg[(crc_on ? 15 : 7) -: 8]};
        rx_wide_next  = rx_wide_reg;
        rx_valid_next = frame_ok;
        if (frame_ok)
            rx_wide_next = cmd_s;
        crc_error_indication_next = frame_end ? crc_err : crc_error_indication_reg;
    end

    // reply word is only rewritten while no frame runs
    always_comb begin
        tx_word_next = tx_word_reg;
        if (cs_s && cs_prev_reg)
            tx_word_next = {status16, crc_error_indication_reg, crc_tx};
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            olf_reg      <= '0;
            thf_reg      <= '0;
            gf_reg       <= '0;
            slow_reg     <= '0;
            hs_reg       <= '0;
            ls_reg       <= '0;
            leds_reg     <= 1'b0;
            wd_cnt_reg   <= '0;
            wd_reg       <= 1'b0;
            sc_cnt_reg   <= '0;
            ckh_reg      <= 1'b0;
            irq_reg      <= 1'b0;
            fault_n_reg  <= 1'b1;
            rx_data_reg  <= '0;
            rx_wide_reg  <= 1'b0;
            rx_valid_reg <= 1'b0;
            crc_error_indication_reg     <= 1'b0;
            tx_word_reg  <= '0;
        end else begin
            olf_reg      <= olf_next;
            thf_reg      <= thf_next;
            gf_reg       <= gf_next;
            slow_reg     <= slow_next;
            hs_reg       <= hs_next;
            ls_reg       <= ls_next;
            leds_reg     <= leds_next;
            wd_cnt_reg   <= wd_cnt_next;
            wd_reg       <= wd_next;
            sc_cnt_reg   <= sc_cnt_next;
            ckh_reg      <= ckh_next;
            irq_reg      <= irq_next;
            fault_n_reg  <= fault_n_next;
            rx_data_reg  <= frame_ok ? rx_data_next : rx_data_reg;
            rx_wide_reg  <= rx_wide_next;
            rx_valid_reg <= rx_valid_next;
            crc_error_indication_reg     <= crc_error_indication_next;
            tx_word_reg  <= tx_word_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign sdo                    = sdo_reg;
    assign high_side_driver       = hs_reg;
    assign low_side_driver        = ls_reg;
    assign slow_mode              = slow_reg;
    assign leds_off               = leds_reg;
    assign fault_n                = fault_n_reg;
    assign watchdog_expiry_output = wd_reg;
    assign crc_error_indication   = crc_error_indication_reg;
    assign clock_count_error_flag = gf_reg[GF_CLKCNT];
    assign ol_flags               = olf_reg;
    assign therm_flags            = thf_reg;
    assign glob_flags             = gf_reg;
    assign rx_data                = rx_data_reg;
    assign rx_wide                = rx_wide_reg;
    assign rx_valid               = rx_valid_reg;
endmodule
`default_nettype wire

// *** tb/sfc_spi_host.sv ***
// spi controller model: whole frames, optional check byte, reply capture
// assumes cs_n idles high; spi_clk stands still between frames
`timescale 1ns/10ps
`default_nettype none
module sfc_spi_host (
    // link pins
    output logic      cs_n,
    output logic      spi_clk,
    output logic      sdi,
    input  wire logic sdo
);
    logic [22:0] reply;

    function automatic logic [6:0] crc7(input logic [16:0] d, input int n);
        logic [6:0] c;
        c = 7'h7F;
        for (int i = n - 1; i >= 0; i--)
            c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h37 : 7'h00);
        return c;
    endfunction

    // bad flips one check bit
    task automatic send(input logic [15:0] d, input int n, input bit crc, input bit bad);
        logic [23:0] w;
        int          len;
        w = {8'h00, d};
        len = n;
        if (crc) begin
            w = (w << 8) | {16'h0000, 1'b1, crc7({d, 1'b1}, n + 1) ^ {6'h00, bad}};
            len = n + 8;
        end
        cs_n = 1'b0;
        for (int i = len - 1; i >= 0; i--) begin
            sdi = w[i];
            #15 spi_clk = 1'b1;
            if (i < len - 1)
                reply = {reply[21:0], sdo};
            #15 spi_clk = 1'b0;
        end
        #15 cs_n = 1'b1;
        // released line shows the inverse
        sdi = ~sdi;
        #100;
    endtask

    initial begin
        cs_n = 1'b1;
        spi_clk = 1'b0;
        sdi = 1'b0;
        reply = '0;
    end
endmodule
`default_nettype wire

// *** tb/sfc_fault_core_assertions.sv ***
// port-level checks on the fault supervisor
// assumes a single core clock domain; bound from tb
`timescale 1ns/10ps
`default_nettype none
module sfc_fault_core_assertions import sfc_pkg::*; (
    // clock, reset and link
    input wire logic           ref_clk,
    input wire logic           rst,
    input wire logic           cs_n,
    input wire logic           cmd_mode,
    // detectors
    input wire logic [NCH-1:0] therm_hs,
    input wire logic [NCH-1:0] therm_ls,
    input wire logic           die_hot,
    input wire logic           vdd_uvlo,
    input wire logic           v5_uvlo,
    input wire logic [NCH-1:0] over_current,
    input wire logic           sc_pulse_off,
    // outputs
    input wire logic [NCH-1:0] high_side_driver,
    input wire logic [NCH-1:0] low_side_driver,
    input wire logic           leds_off,
    input wire logic           fault_n,
    input wire logic           watchdog_expiry_output,
    input wire logic           crc_error_indication,
    input wire logic           clock_count_error_flag,
    input wire logic [7:0]     glob_flags
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // six cycles cover synchroniser and output register
    sequence s_hot_die; die_hot [*6]; endsequence
    sequence s_wd_rearm; watchdog_expiry_output && $fell(cs_n); endsequence

    a_chan_heat_off: assert property (((therm_hs | therm_ls) != 0) [*6] |->
        ((therm_hs | therm_ls) & (high_side_driver | low_side_driver)) == 0) else $error("hot channel driven");
    a_die_all_off: assert property (s_hot_die |-> high_side_driver == 0 && low_side_driver == 0)
        else $error("die hot but drivers on");
    a_uvlo_all_off: assert property ((vdd_uvlo || v5_uvlo) [*6] |-> leds_off && high_side_driver == 0
        && low_side_driver == 0) else $error("lockout but outputs on");
    a_wd_pin_rearm: assert property (s_wd_rearm |-> ##[1:5] !watchdog_expiry_output)
        else $error("watchdog pin stuck after select");
    a_wd_flag_set: assert property ($rose(watchdog_expiry_output) |-> glob_flags[7])
        else $error("watchdog flag missing");
    a_ccnt_copy: assert property (clock_count_error_flag == glob_flags[4])
        else $error("clock count flag mismatch");
    a_crc_error_indication_flag_set: assert property ($rose(crc_error_indication) |-> glob_flags[6])
        else $error("crc flag missing");
    a_short_pulse: assert property ($rose(|over_current) && !sc_pulse_off |-> ##[1:8] !fault_n)
        else $error("no short circuit pulse");
    a_clear_by_frame: assert property ($fell(glob_flags[4]) |-> cmd_mode && cs_n)
        else $error("flag cleared outside a command frame");
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the fault supervisor
// assumes the spi model and shortened hold, watchdog and pulse counts
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        ref_clk, rst, spi_clk, cs_n, sdi, sdo, fault_n, leds_off, rx_wide, rx_valid;
    logic        crc_enable_input, serial_setting_select, cmd_mode, die_hot, vdd_warn, vdd_uvlo, v5_uvlo;
    logic        dcdc_limit, sc_pulse_off, watchdog_expiry_output, crc_error_indication, clock_count_error_flag;
    logic [7:0]  therm_hs, therm_ls, ol_on_low, ol_off_low, over_current, hs_cmd, ls_cmd, pp_mode, ol_en;
    logic [7:0]  high_side_driver, low_side_driver, slow_mode, ol_flags, therm_flags, glob_flags;
    logic [15:0] rx_data;
    logic [1:0]  wd_sel;
    int          miscompares = 0;
    int          n_checks = 0;

    sfc_fault_core #(.THERM_HOLD(26'h32), .WD_LONG_T(28'h12C), .WD_MID_T(28'hC8), .WD_SHORT_T(28'h64),
        .SC_PULSE(15'h14)) sfc_fault_core_i (.ref_clk, .rst, .spi_clk, .cs_n, .sdi, .sdo, .crc_enable_input,
        .serial_setting_select, .cmd_mode, .therm_hs, .therm_ls, .die_hot, .vdd_warn, .vdd_uvlo, .v5_uvlo,
        .dcdc_limit, .ol_on_low, .ol_off_low, .over_current, .hs_cmd, .ls_cmd, .pp_mode, .ol_en, .wd_sel,
        .sc_pulse_off, .high_side_driver, .low_side_driver, .slow_mode, .leds_off, .fault_n,
        .watchdog_expiry_output, .crc_error_indication, .clock_count_error_flag, .ol_flags, .therm_flags,
        .glob_flags, .rx_data, .rx_wide, .rx_valid);
    sfc_spi_host sfc_spi_host_i (.cs_n, .spi_clk, .sdi, .sdo);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (miscompares == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic frame(input logic [15:0] d, input int n, input bit crc, input bit bad);
        sfc_spi_host_i.send(d, n, crc, bad);
        cyc(12);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        #100us;
        miscompares++;
        print_verdict;
    end

    initial begin
        rst = 1'b1;
        {therm_hs, therm_ls, ol_on_low, ol_off_low, over_current, ls_cmd, pp_mode, ol_en} = '0;
        {die_hot, vdd_warn, vdd_uvlo, v5_uvlo, dcdc_limit, sc_pulse_off, cmd_mode, crc_enable_input} = '0;
        hs_cmd = 8'hFF;
        serial_setting_select = 1'b1;
        wd_sel = 2'h0;
        cyc(10);
        rst = 1'b0;
        cyc(5);
        chk({fault_n, watchdog_expiry_output, rx_valid, glob_flags}, {3'h4, 8'h00});
        frame(16'h00A5, 8, 0, 0);
        chk({rx_wide, rx_data}, 17'h000A5);
        frame(16'h005A, 7, 0, 0);
        chk({clock_count_error_flag, fault_n, rx_data}, {2'h2, 16'h00A5});
        frame(16'h003C, 8, 0, 0);
        chk({fault_n, rx_data}, {1'b1, 16'h003C});
        cmd_mode = 1'b1;
        crc_enable_input = 1'b1;
        cyc(6);
        frame(16'h0033, 16, 1, 0);
        chk({rx_wide, rx_data}, 17'h10033);
        frame(16'h0044, 16, 1, 1);
        chk({crc_error_indication, glob_flags[6], fault_n, rx_data}, {3'h6, 16'h0033});
        frame(16'h0055, 16, 1, 0);
        chk({sfc_spi_host_i.reply[7], fault_n, rx_data}, {2'h2, 16'h0055});
        frame(16'h8000, 16, 1, 1);
        chk({fault_n, glob_flags[6]}, 2'h1);
        frame(16'h8000, 16, 1, 0);
        chk({fault_n, glob_flags}, {1'b1, 8'h00});
        cmd_mode = 1'b0;
        crc_enable_input = 1'b0;
        therm_hs = 8'h04;
        cyc(8);
        chk({high_side_driver, therm_flags}, {8'hFB, 8'h04});
        therm_hs = 8'h00;
        cyc(30);
        chk(fault_n, 1'b0);
        cyc(40);
        chk({fault_n, therm_flags}, {1'b1, 8'h04});
        die_hot = 1'b1;
        cyc(8);
        chk({high_side_driver, glob_flags[3]}, {8'h00, 1'b1});
        die_hot = 1'b0;
        for (int k = 0; k < 2; k++) begin
            {v5_uvlo, vdd_uvlo} = 2'h1 << k;
            cyc(8);
            chk({leds_off, high_side_driver, glob_flags[2:1]}, {1'b1, 8'h00, k ? 2'h3 : 2'h1});
        end
        {v5_uvlo, vdd_uvlo} = 2'h0;
        over_current = 8'h02;
        cyc(6);
        chk({slow_mode, fault_n}, {8'h02, 1'b0});
        cyc(30);
        chk(fault_n, 1'b1);
        ol_en = 8'h08;
        ol_on_low = 8'h18;
        cyc(8);
        chk(ol_flags, 8'h08);
        ol_on_low = 8'h00;
        wd_sel = 2'h3;
        cyc(130);
        chk({watchdog_expiry_output, glob_flags[7]}, 2'h3);
        frame(16'h0001, 8, 0, 0);
        chk(watchdog_expiry_output, 1'b0);
        print_verdict;
    end
endmodule

bind sfc_fault_core sfc_fault_core_assertions chk_i (.ref_clk, .rst, .cs_n, .cmd_mode, .therm_hs, .therm_ls,
    .die_hot, .vdd_uvlo, .v5_uvlo, .over_current, .sc_pulse_off, .high_side_driver, .low_side_driver, .leds_off,
    .fault_n, .watchdog_expiry_output, .crc_error_indication, .clock_count_error_flag, .glob_flags);
`default_nettype wire
